// ---- include/kbc_host_pkg.sv ----
// constants for the keyboard mailbox status and fast system control port
package kbc_host_pkg;
    // -------------------------------------------------------------------------
    // host i/o map
    // -------------------------------------------------------------------------
    localparam logic [15:0] DataPortAddr    = 16'h0060;
    localparam logic [15:0] StatusPortAddr  = 16'h0064;
    localparam logic [15:0] FastCtrlAddr    = 16'h0092;
    localparam int          CmdAddrBit      = 2;
    // -------------------------------------------------------------------------
    // status register layout
    // -------------------------------------------------------------------------
    localparam int          StatCmdBit      = 3;
    localparam int          StatInFullBit   = 1;
    localparam int          StatOutFullBit  = 0;
    localparam logic [7:0]  StatUserMask    = 8'hf4;
    localparam logic [7:0]  StatReset       = 8'h00;
    // -------------------------------------------------------------------------
    // fast control port layout
    // -------------------------------------------------------------------------
    localparam logic [7:0]  FastReadFixed   = 8'h24;
    localparam logic [7:0]  FastReset       = 8'h24;
    localparam int          FastA20Bit      = 1;
    localparam int          FastRstBit      = 0;
    localparam int          CfgFastEnBit    = 2;
    localparam int          CfgHwA20Bit     = 1;
    localparam int          CfgHwRstBit     = 0;
    localparam logic [7:0]  ClockCtrlReset  = 8'h80;
    // -------------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------------
    localparam int          ClkPeriodPs     = 10000;
    localparam int          AltRstDelayNs   = 500;
    localparam int          AltRstWidthNs   = 1000;
    localparam int          AltRstDelayCyc  = (AltRstDelayNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs;
    localparam int          AltRstWidthCyc  = (AltRstWidthNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs;
    localparam int          MinResetCycles  = 24;
    typedef enum logic [1:0] {
        PulseIdle  = 2'b00,
        PulseDelay = 2'b01,
        PulseLow   = 2'b10,
        PulseDone  = 2'b11
    } pulse_state_type;
endpackage

// ---- include/sync_bus_if.sv ----
// bundle carrying a synchronised host strobe pair between modules
`timescale 1ns/1ns
interface sync_bus_if;
    logic readPulse;
    logic writePulse;
    logic readLevel;
    modport src (output readPulse, output writePulse, output readLevel);
    modport dst (input readPulse, input writePulse, input readLevel);
endinterface

// ---- hdl/strobe_sync.sv ----
// three-stage synchroniser and edge detect for the host read/write strobes
`timescale 1ns/1ns
module strobe_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // raw active-low strobes from pins
    input  wire logic ioRead_n,
    input  wire logic ioWrite_n,
    // one-cycle pulses at strobe assertion
    sync_bus_if.src   bus
);
    logic [2:0] rdSync_r;
    logic [2:0] wrSync_r;
    logic       rdLevel_r;
    logic       wrLevel_r;
    // a level change counts once stages two and three agree
    wire rdStable = rdSync_r[1] == rdSync_r[2];
    wire wrStable = wrSync_r[1] == wrSync_r[2];
    wire rdNxt    = rdStable ? ~rdSync_r[2] : rdLevel_r;
    wire wrNxt    = wrStable ? ~wrSync_r[2] : wrLevel_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            rdSync_r  <= 3'h7;
            wrSync_r  <= 3'h7;
            rdLevel_r <= 1'b0;
            wrLevel_r <= 1'b0;
        end else begin
            rdSync_r  <= {rdSync_r[1:0], ioRead_n};
            wrSync_r  <= {wrSync_r[1:0], ioWrite_n};
            rdLevel_r <= rdNxt;
            wrLevel_r <= wrNxt;
        end
    end
    assign bus.readPulse  = rdNxt & ~rdLevel_r;
    assign bus.writePulse = wrNxt & ~wrLevel_r;
    // settled read level, high from the cycle after the pulse until the pin settles high
    assign bus.readLevel  = rdLevel_r;
endmodule

// ---- hdl/alt_reset_pulse.sv ----
// delayed low pulse generator for the alternate cpu reset
`timescale 1ns/1ns
module alt_reset_pulse
    import kbc_host_pkg::*;
#(
    parameter int DelayCycles = AltRstDelayCyc,
    parameter int WidthCycles = AltRstWidthCyc
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // fast port reset bit level
    input  wire logic resetBit,
    // pulse output, active low
    output logic      pulseOut_n
);
    // counters are 16 bits wide and need at least one cycle per phase
    if (DelayCycles < 1 || WidthCycles < 1 ||
        DelayCycles > 65535 || WidthCycles > 65535) begin : g_bad_counts
        $error("alt_reset_pulse: cycle counts out of range");
    end
    pulse_state_type state_r;
    pulse_state_type state_nxt;
    logic [15:0]     count_r;
    logic [15:0]     count_nxt;
    logic            out_nxt;
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        case (state_r)
            PulseIdle: begin
                if (resetBit) begin
                    state_nxt = PulseDelay;
                    count_nxt = 16'(DelayCycles - 1);
                end
            end
            PulseDelay: begin
                if (count_r == 16'h0000) begin
                    state_nxt = PulseLow;
                    count_nxt = 16'(WidthCycles - 1);
                end else begin
                    count_nxt = count_r - 16'h0001;
                end
            end
            PulseLow: begin
                if (count_r == 16'h0000) begin
                    state_nxt = PulseDone;
                end else begin
                    count_nxt = count_r - 16'h0001;
                end
            end
            PulseDone: begin
                // rearm only after the bit is written back to zero
                if (!resetBit) begin
                    state_nxt = PulseIdle;
                end
            end
            default: state_nxt = PulseIdle;
        endcase
    end
    // outputs registered; the low phase covers the whole PulseLow state
    assign out_nxt = state_nxt != PulseLow;
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r    <= PulseIdle;
            count_r    <= 16'h0000;
            pulseOut_n <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            count_r    <= count_nxt;
            pulseOut_n <= out_nxt;
        end
    end
endmodule

// ---- hdl/kbc_host_port.sv ----
// host status register, mailbox flags and fast system control port
`timescale 1ns/1ns
module kbc_host_port
    import kbc_host_pkg::*;
#(
    parameter int DelayCycles = AltRstDelayCyc,
    parameter int WidthCycles = AltRstWidthCyc
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // host i/o bus
    input  wire logic [15:0] hostAddr,
    input  wire logic       addrEnable,
    input  wire logic       ioRead_n,
    input  wire logic       ioWrite_n,
    input  wire logic [7:0] hostDataIn,
    output logic      [7:0] hostDataOut,
    output logic            hostDataOe_n,
    // microcontroller side
    input  wire logic       mcuReadIn,
    input  wire logic       mcuWriteOut,
    input  wire logic [7:0] mcuOutData,
    input  wire logic       mcuStatusWrite,
    input  wire logic [7:0] mcuStatusData,
    input  wire logic       mcuIntEnable,
    input  wire logic       mcuA20PortBit,
    input  wire logic [7:0] fastPathConfig,
    output logic      [7:0] mcuInData,
    output logic      [7:0] mcuStatus,
    output logic            inputFullInterrupt_n,
    // system outputs
    output logic            alternateA20Line,
    output logic            alternateCpuReset_n,
    output logic            cpuA20Mask_n,
    // serial line releases and clock control
    output logic            kbdClockPinOe_n,
    output logic            kbdDataPinOe_n,
    output logic            mouseClockPinOe_n,
    output logic            mouseDataPinOe_n,
    output logic      [7:0] clockControlReg
);
    // -------------------------------------------------------------------------
    // strobe synchronisation
    // -------------------------------------------------------------------------
    sync_bus_if strobes ();
    strobe_sync u_sync (
        .clk       (clk),
        .rst       (rst),
        .ioRead_n  (ioRead_n),
        .ioWrite_n (ioWrite_n),
        .bus       (strobes.src)
    );
    // address and data pins sampled through three stages like the strobes
    logic [15:0] addrS1_r, addrS2_r, addrS3_r;
    logic [7:0]  dataS1_r, dataS2_r, dataS3_r;
    logic        aenS1_r, aenS2_r, aenS3_r;
    always_ff @(posedge clk) begin
        addrS1_r <= hostAddr;
        addrS2_r <= addrS1_r;
        addrS3_r <= addrS2_r;
        dataS1_r <= hostDataIn;
        dataS2_r <= dataS1_r;
        dataS3_r <= dataS2_r;
        aenS1_r  <= addrEnable;
        aenS2_r  <= aenS1_r;
        aenS3_r  <= aenS2_r;
    end
    // -------------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        return a == target;
    endfunction
    // aen high marks a dma cycle, so i/o decode waits for it low
    wire ioCycle  = ~aenS3_r;
    wire fastEn   = fastPathConfig[CfgFastEnBit];
    wire selData  = ioCycle & hit(addrS3_r, DataPortAddr);
    wire selStat  = ioCycle & hit(addrS3_r, StatusPortAddr);
    wire selFast  = ioCycle & hit(addrS3_r, FastCtrlAddr) & fastEn;
    wire hostWrIn = strobes.writePulse & (selData | selStat);
    wire hostRdOut = strobes.readPulse & selData;
    wire fastWr   = strobes.writePulse & selFast;
    // -------------------------------------------------------------------------
    // mailbox flags and buffers
    // -------------------------------------------------------------------------
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] inBuf_r;
    logic [7:0] outBuf_r;
    always_comb begin
        status_nxt = status_r;
        if (mcuStatusWrite) begin
            // only user bits are software owned; flags stay hardware driven
            status_nxt = (status_r & ~StatUserMask) | (mcuStatusData & StatUserMask);
        end
        if (mcuReadIn) begin
            status_nxt[StatInFullBit] = 1'b0;
        end
        if (hostRdOut) begin
            status_nxt[StatOutFullBit] = 1'b0;
        end
        // sets placed last so an event beats a simultaneous clear
        if (hostWrIn) begin
            status_nxt[StatCmdBit]    = addrS3_r[CmdAddrBit];
            status_nxt[StatInFullBit] = 1'b1;
        end
        if (mcuWriteOut) begin
            status_nxt[StatOutFullBit] = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            status_r <= StatReset;
            inBuf_r  <= 8'h00;
            outBuf_r <= 8'h00;
        end else begin
            status_r <= status_nxt;
            if (hostWrIn) begin
                inBuf_r <= dataS3_r;
            end
            if (mcuWriteOut) begin
                outBuf_r <= mcuOutData;
            end
        end
    end
    // -------------------------------------------------------------------------
    // fast system control port
    // -------------------------------------------------------------------------
    logic [1:0] fastBits_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            fastBits_r <= FastReset[1:0];
        end else if (fastWr) begin
            fastBits_r <= dataS3_r[1:0];
        end
    end
    wire [7:0] fastRead = {FastReadFixed[7:2], fastBits_r};
    logic altRstPulse_n;
    alt_reset_pulse #(
        .DelayCycles (DelayCycles),
        .WidthCycles (WidthCycles)
    ) u_pulse (
        .clk        (clk),
        .rst        (rst),
        .resetBit   (fastBits_r[FastRstBit]),
        .pulseOut_n (altRstPulse_n)
    );
    // -------------------------------------------------------------------------
    // host read data
    // -------------------------------------------------------------------------
    // synchronised read pulse and settled read level only: the raw pin would let a glitch drop the bus early
    wire rdActive = strobes.readPulse | strobes.readLevel;
    wire [7:0] rdMux = selStat ? status_r : selData ? outBuf_r : fastRead;
    wire rdDrive = rdActive & (selStat | selData | selFast);
    // -------------------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            hostDataOut          <= 8'h00;
            hostDataOe_n         <= 1'b1;
            mcuInData            <= 8'h00;
            mcuStatus            <= StatReset;
            inputFullInterrupt_n <= 1'b1;
            alternateA20Line     <= 1'b0;
            alternateCpuReset_n  <= 1'b1;
            cpuA20Mask_n         <= 1'b0;
            kbdClockPinOe_n      <= 1'b1;
            kbdDataPinOe_n       <= 1'b1;
            mouseClockPinOe_n    <= 1'b1;
            mouseDataPinOe_n     <= 1'b1;
            clockControlReg      <= ClockCtrlReset;
        end else begin
            hostDataOut          <= rdMux;
            hostDataOe_n         <= ~rdDrive;
            mcuInData            <= inBuf_r;
            mcuStatus            <= status_nxt;
            // in-full exists only as an mcu interrupt, never a host pin
            inputFullInterrupt_n <= ~(status_nxt[StatInFullBit] & mcuIntEnable);
            alternateA20Line     <= fastBits_r[FastA20Bit];
            alternateCpuReset_n  <= altRstPulse_n;
            cpuA20Mask_n         <= fastBits_r[FastA20Bit] | mcuA20PortBit;
        end
    end
endmodule

// ---- dv/kbc_host_port_properties.sv ----
// assertions on the mailbox and fast control port pins
`timescale 1ns/1ns
module kbc_host_port_properties #(
    parameter int WidthCycles = 100
) (
    // clock, reset and host strobes
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ioRead_n,
    input wire logic       ioWrite_n,
    input wire logic       hostDataOe_n,
    // mcu side and system outputs
    input wire logic       mcuReadIn,
    input wire logic       mcuA20PortBit,
    input wire logic       inputFullInterrupt_n,
    input wire logic       alternateA20Line,
    input wire logic       alternateCpuReset_n,
    input wire logic       cpuA20Mask_n,
    input wire logic       kbdClockPinOe_n,
    input wire logic       kbdDataPinOe_n,
    input wire logic       mouseClockPinOe_n,
    input wire logic       mouseDataPinOe_n,
    input wire logic [7:0] clockControlReg
);
    logic [15:0] lowCnt_r;
    wire         a20Src = alternateA20Line | mcuA20PortBit;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------
    // pulse width counter, read at the rising edge
    // ------------------------------------------------
    always_ff @(posedge clk) begin
        lowCnt_r <= (rst || alternateCpuReset_n) ? 16'h0000 : lowCnt_r + 16'h0001;
    end
    property p_rst_vals;
        $fell(rst) |-> alternateCpuReset_n && !alternateA20Line && hostDataOe_n;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs wrong after reset");
    property p_lines;
        kbdClockPinOe_n && kbdDataPinOe_n && mouseClockPinOe_n && mouseDataPinOe_n
            && clockControlReg == 8'h80;
    endproperty
    a_lines: assert property (p_lines) else $error("serial lines or clock control wrong");
    property p_oe_idle; ioRead_n [*6] |-> hostDataOe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("bus driven without read");
    property p_a20_hi; a20Src [*4] |-> $past(cpuA20Mask_n); endproperty
    a_a20_hi: assert property (p_a20_hi) else $error("a20 mask low with a source high");
    property p_a20_lo; !a20Src [*4] |-> !$past(cpuA20Mask_n); endproperty
    a_a20_lo: assert property (p_a20_lo) else $error("a20 mask high with sources low");
    property p_int_clr; mcuReadIn |-> ##[1:2] inputFullInterrupt_n; endproperty
    a_int_clr: assert property (p_int_clr) else $error("interrupt not withdrawn");
    property p_a20_hold; ioWrite_n [*8] |-> $stable(alternateA20Line); endproperty
    a_a20_hold: assert property (p_a20_hold) else $error("a20 line moved without write");
    property p_width;
        $rose(alternateCpuReset_n) |-> lowCnt_r >= WidthCycles && lowCnt_r <= WidthCycles + 2;
    endproperty
    a_width: assert property (p_width) else $error("reset pulse width wrong");
    c_pulse: cover property ($rose(alternateCpuReset_n));
    c_read: cover property ($fell(hostDataOe_n));
    c_irq: cover property ($fell(inputFullInterrupt_n));
endmodule
bind kbc_host_port kbc_host_port_properties #(.WidthCycles(WidthCycles))
    kbc_host_port_properties_i (.clk, .rst, .ioRead_n, .ioWrite_n, .hostDataOe_n,
    .mcuReadIn, .mcuA20PortBit, .inputFullInterrupt_n, .alternateA20Line,
    .alternateCpuReset_n, .cpuA20Mask_n, .kbdClockPinOe_n, .kbdDataPinOe_n,
    .mouseClockPinOe_n, .mouseDataPinOe_n, .clockControlReg);

// ---- dv/host_bus_model.sv ----
// behavioural isa host: drives strobes, samples read data
`timescale 1ns/1ns
module host_bus_model (
    // clock
    input wire logic        clk,
    // host side of the bus
    output logic     [15:0] hostAddr,
    output logic            addrEnable,
    output logic            ioRead_n,
    output logic            ioWrite_n,
    output logic     [7:0]  hostDataIn,
    // device answer and what the host took
    input wire logic [7:0]  hostDataOut,
    input wire logic        hostDataOe_n,
    output logic            rdDone,
    output logic     [8:0]  rdVal
);
    initial {hostAddr, addrEnable, ioRead_n, ioWrite_n, hostDataIn, rdDone, rdVal} = 37'h0c0000;
    // ------------------------------------------------
    // one access: strobe low 7 edges, high 5 edges
    // ------------------------------------------------
    // both phases exceed the four cycles the synchroniser needs
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          input logic aen);
        @(posedge clk);
        #1;
        hostAddr = a;
        addrEnable = aen;
        hostDataIn = wr ? d : ~hostDataIn;
        ioWrite_n = !wr;
        ioRead_n = wr;
        repeat (7) @(posedge clk);
        #1;
        rdVal = {!hostDataOe_n, hostDataOe_n ? 8'h00 : hostDataOut};
        rdDone = !wr;
        {ioWrite_n, ioRead_n} = 2'b11;
        hostDataIn = ~hostDataIn;
        @(posedge clk);
        #1;
        rdDone = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule

// ---- dv/kbc_host_port_tb.sv ----
// self-checking bench for the mailbox status and fast control port
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    $display("mismatch %s exp %h got %h", nm, e, g); n_errors++; end end
module kbc_host_port_tb
    import kbc_host_pkg::*;
;
    localparam int DelayCyc = 20;
    localparam int WidthCyc = 30;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] hostAddr;
    logic [7:0]  hostDataIn, hostDataOut, mcuOutData, mcuStatusData, fastPathConfig;
    logic [7:0]  mcuInData, mcuStatus, clockControlReg, d;
    logic        addrEnable, ioRead_n, ioWrite_n, hostDataOe_n, mcuReadIn, mcuWriteOut;
    logic        mcuStatusWrite, mcuIntEnable, mcuA20PortBit, inputFullInterrupt_n;
    logic        alternateA20Line, alternateCpuReset_n, cpuA20Mask_n, kbdClockPinOe_n;
    logic        kbdDataPinOe_n, mouseClockPinOe_n, mouseDataPinOe_n, rdDone;
    // bit 8 of a read note marks a driven bus
    logic [8:0]  rdVal, expV;
    logic [8:0]  expQ[$];
    int          n_errors = 0;
    int          check_count = 0;
    kbc_host_port #(.DelayCycles(DelayCyc), .WidthCycles(WidthCyc)) kbc_host_port_i (.*);
    host_bus_model host_bus_model_i (.*);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (rdDone === 1'b1) begin
            if (expQ.size() == 0) begin
                n_errors++;
            end else begin
                expV = expQ.pop_front();
                `CHECK("readData", expV, rdVal)
            end
        end
    end
    task automatic rd(input logic [15:0] a, input logic [8:0] e);
        expQ.push_back(e);
        host_bus_model_i.access(1'b0, a, 8'h00, 1'b0);
    endtask
    task automatic mcu(input int k);
        @(posedge clk);
        #1;
        {mcuReadIn, mcuWriteOut, mcuStatusWrite} = 3'b100 >> k;
        @(posedge clk);
        #1;
        {mcuReadIn, mcuWriteOut, mcuStatusWrite} = 3'b000;
    endtask
    task automatic ptest(input logic [7:0] v, input logic pulse);
        int n, dly;
        fork
            host_bus_model_i.access(1'b1, FastCtrlAddr, v, 1'b0);
            for (n = 0; n < 90 && alternateCpuReset_n === 1'b1; n++) @(posedge clk) #1;
        join
        dly = n;
        for (; n < 300 && alternateCpuReset_n !== 1'b1; n++) @(posedge clk) #1;
        `CHECK("pulse", pulse, dly < 90)
        if (pulse) `CHECK("delay", 1'b1, dly >= DelayCyc && dly <= DelayCyc + 8)
        if (pulse) `CHECK("width", 1'b1, n - dly >= WidthCyc && n - dly <= WidthCyc + 2)
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {mcuReadIn, mcuWriteOut, mcuStatusWrite, mcuA20PortBit} = 4'h0;
        {mcuOutData, mcuStatusData} = 16'h0000;
        mcuIntEnable = 1'b1;
        fastPathConfig = 8'h04;
        void'($urandom(2697));
        repeat (24) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        rd(StatusPortAddr, {1'b1, StatReset});
        rd(FastCtrlAddr, {1'b1, FastReset});
        rd(16'h0061, 9'h000);
        $display("test reset done");
        d = $urandom;
        host_bus_model_i.access(1'b1, DataPortAddr, d, 1'b0);
        `CHECK("inData", d, mcuInData)
        `CHECK("irqOn", 1'b0, inputFullInterrupt_n)
        mcuIntEnable = 1'b0;
        repeat (3) @(posedge clk) #1;
        `CHECK("irqMasked", 1'b1, inputFullInterrupt_n)
        mcuIntEnable = 1'b1;
        rd(StatusPortAddr, 9'h102);
        host_bus_model_i.access(1'b1, StatusPortAddr, ~d, 1'b0);
        rd(StatusPortAddr, 9'h10a);
        mcu(0);
        rd(StatusPortAddr, 9'h108);
        `CHECK("irqClr", 1'b1, inputFullInterrupt_n)
        d = $urandom;
        mcuOutData = d;
        mcu(1);
        rd(StatusPortAddr, 9'h109);
        rd(DataPortAddr, {1'b1, d});
        host_bus_model_i.access(1'b1, DataPortAddr, d, 1'b1);
        rd(StatusPortAddr, 9'h108);
        d = $urandom;
        mcuStatusData = d;
        mcu(2);
        rd(StatusPortAddr, {1'b1, d & StatUserMask | 8'h08});
        `CHECK("mcuStatus", d & StatUserMask | 8'h08, mcuStatus)
        $display("test mailbox done");
        ptest(8'h01, 1'b1);
        ptest(8'h01, 1'b0);
        ptest(8'h00, 1'b0);
        ptest(8'h01, 1'b1);
        for (int i = 0; i < 4; i++) begin
            mcuA20PortBit = i[0];
            d = $urandom;
            d[1:0] = {i[1], 1'b0};
            host_bus_model_i.access(1'b1, FastCtrlAddr, d, 1'b0);
            `CHECK("a20", i[1], alternateA20Line)
            `CHECK("mask", i[0] | i[1], cpuA20Mask_n)
            rd(FastCtrlAddr, {1'b1, FastReadFixed | {6'h00, d[1:0]}});
        end
        fastPathConfig = 8'h00;
        ptest(8'h01, 1'b0);
        `CHECK("a20Held", 1'b1, alternateA20Line)
        rd(FastCtrlAddr, 9'h000);
        $display("test fast port done");
        repeat (2) @(posedge clk);
        if (expQ.size() != 0) begin
            n_errors++;
        end
        results();
    end
endmodule
